// ==== ers_map.svh ====
// Register offsets, field positions, reset values and codes of the extended ALU
// Functional notes
// - OR accumulator into memory byte, write back, update zero flag only.
// - Rotate memory byte left, bit 7 into bit 0, flags unchanged.
// - Left-rotated byte to accumulator only; memory and flags unchanged.
// - Nine-bit left rotate through carry into memory; only carry changes.
// - Nine-bit left rotate through carry into accumulator; memory unchanged.
// - Rotate memory byte right, bit 0 into bit 7, flags unchanged.
// - Right-rotated byte to accumulator only; memory and flags unchanged.
// - Nine-bit right rotate through carry into memory; only carry changes.
// - Nine-bit right rotate through carry into accumulator; memory unchanged.
// - Accumulator minus byte minus not-carry into accumulator; six flags.
// - Same borrow subtract written into memory byte; same six flags.
// - Decrement byte in memory; skip next when zero; flags untouched.
// - Byte minus one into accumulator; skip next when zero; no flags.
// - Set every bit of memory byte; flags untouched.
// - Set selected bit of memory byte; other bits and flags untouched.
// - Increment byte in memory; skip next when zero; flags untouched.
// - Byte plus one into accumulator; skip next when zero; no flags.
// - Skip next when selected bit is set; no data or flag change.
// - Skip next when whole byte nonzero; no data or flag change.
// - Every conditional skip not dropped by a pending skip takes two cycles with an inserted dummy.
// - Operand addressed directly anywhere in data memory, no section select.
`ifndef ERS_MAP_SVH
`define ERS_MAP_SVH
// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define ERS_CMD_OFS 8'h00
`define ERS_ACC_OFS 8'h04
`define ERS_FLAG_OFS 8'h08
`define ERS_MPTR_OFS 8'h0c
`define ERS_MDAT_OFS 8'h10
`define ERS_STAT_OFS 8'h14
`define ERS_SCNT_OFS 8'h18
// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define ERS_CMD_OP_LSB 0
`define ERS_CMD_BIT_LSB 8
`define ERS_CMD_ADDR_LSB 16
`define ERS_STAT_BUSY 0
`define ERS_STAT_SKIP_PEND 1
`define ERS_STAT_LAST_SKIP 2
`define ERS_MEM_AW 9
// ---------------------------------------------------------------------------
// Reset values and bus codes
// ---------------------------------------------------------------------------
`define ERS_ACC_RST 8'h00
`define ERS_FLAG_RST 6'h00
`define ERS_RESP_OKAY 2'b00
`define ERS_RESP_SLVERR 2'b10
`endif

// ==== ers_pkg.sv ====
// Types shared by the extended ALU: operation codes, flags, command, states
package ers_pkg;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_OR_ACC_INTO_MEMORY = 5'h01,
    OP_ROTATE_LEFT_MEM = 5'h02,
    OP_ROTATE_LEFT_TO_ACC = 5'h03,
    OP_ROTATE_LEFT_THRU_CARRY_MEM = 5'h04,
    OP_ROTATE_LEFT_THRU_CARRY_TO_ACC = 5'h05,
    OP_ROTATE_RIGHT_MEM = 5'h06,
    OP_ROTATE_RIGHT_TO_ACC = 5'h07,
    OP_ROTATE_RIGHT_THRU_CARRY_MEM = 5'h08,
    OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC = 5'h09,
    OP_SUBTRACT_BORROW_TO_ACC = 5'h0a,
    OP_SUBTRACT_BORROW_TO_MEM = 5'h0b,
    OP_DECREMENT_SKIP_ZERO = 5'h0c,
    OP_DECREMENT_TO_ACC_SKIP_ZERO = 5'h0d,
    OP_SET_ONES = 5'h0e,
    OP_SET_BIT = 5'h0f,
    OP_INCREMENT_SKIP_ZERO = 5'h10,
    OP_INCREMENT_TO_ACC_SKIP_ZERO = 5'h11,
    OP_SKIP_IF_NONZERO_BIT = 5'h12,
    OP_SKIP_IF_NONZERO = 5'h13
  } ers_op_t;

  // Status flags, bit 0 is carry
  typedef struct packed {
    logic zero_carry_flag;
    logic signed_carry_flag;
    logic overflow_flag;
    logic z;
    logic nibble_carry_flag;
    logic c;
  } ers_flags_t;

  // One launched operation
  typedef struct packed {
    logic [8:0] addr;
    logic [2:0] bsel;
    logic [4:0] op;
  } ers_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DUMMY = 2'b11
  } ers_state_t;

endpackage

// ==== ers_alu.sv ====
// Extended-group ALU datapath with its data memory behind an AXI4-Lite slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ers_map.svh"
module ers_alu
  import ers_pkg::*;
#(
  parameter int MEM_DEPTH = 384
)
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic BUSY,
  output logic SKIP_PENDING
);

  // Memory must fit the direct operand address
  if (MEM_DEPTH < 1 || MEM_DEPTH > (1 << `ERS_MEM_AW))
  begin : g_bad_depth
    $error("MEM_DEPTH does not fit the operand address");
  end

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [7:0] mem_r [MEM_DEPTH];
  logic [7:0] acc_r;
  ers_flags_t flags_r;
  ers_cmd_t cmd_r;
  ers_state_t state_r;
  logic [8:0] mptr_r;
  logic skip_pend_r;
  logic last_skip_r;
  logic [7:0] scnt_r;
  logic aw_full_r;
  logic [7:0] aw_addr_r;
  logic w_full_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_wr;
  logic wr_hit;
  logic launch;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [7:0] opnd;
  logic [7:0] res;
  logic mem_we;
  logic acc_we;
  logic flag_we;
  ers_flags_t flags_nxt;
  logic is_skip;
  logic skip_cond;
  logic suppress;
  logic [8:0] diff9;
  logic [4:0] nib5;

  // Byte-lane merge of a bus write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // AXI4-Lite write side
  // ---------------------------------------------------------------------------
  assign S_AXI_AWREADY = !aw_full_r;
  assign S_AXI_WREADY = !w_full_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  // A write completes only while no operation is in flight
  assign do_wr = aw_full_r && w_full_r && !bvalid_r && (state_r == ST_IDLE);
  assign launch = do_wr && (aw_addr_r == `ERS_CMD_OFS) && w_strb_r[0];

  // Known write offsets
  always_comb
  begin
    unique case (aw_addr_r)
      `ERS_CMD_OFS, `ERS_ACC_OFS, `ERS_FLAG_OFS, `ERS_MPTR_OFS,
      `ERS_MDAT_OFS, `ERS_STAT_OFS, `ERS_SCNT_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Address and data are captured in either order
  always_ff @(posedge CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_full_r)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      else if (do_wr)
      begin
        aw_full_r <= 1'b0;
      end
      if (S_AXI_WVALID && !w_full_r)
      begin
        w_full_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      else if (do_wr)
      begin
        w_full_r <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `ERS_RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? `ERS_RESP_OKAY : `ERS_RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
    begin
      bvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read side
  // ---------------------------------------------------------------------------
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // Read data selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({S_AXI_ARADDR[7:2], 2'b00})
      `ERS_CMD_OFS: rd_mux = {7'h00, cmd_r.addr, 5'h00, cmd_r.bsel,
                              3'h0, cmd_r.op};
      `ERS_ACC_OFS: rd_mux = {24'h00_0000, acc_r};
      `ERS_FLAG_OFS: rd_mux = {26'h000_0000, flags_r};
      `ERS_MPTR_OFS: rd_mux = {23'h00_0000, mptr_r};
      `ERS_MDAT_OFS: rd_mux = (32'(mptr_r) < MEM_DEPTH) ?
                              {24'h00_0000, mem_r[mptr_r]} : 32'h0000_0000;
      `ERS_STAT_OFS:
      begin
        rd_mux[`ERS_STAT_BUSY] = (state_r != ST_IDLE);
        rd_mux[`ERS_STAT_SKIP_PEND] = skip_pend_r;
        rd_mux[`ERS_STAT_LAST_SKIP] = last_skip_r;
      end
      `ERS_SCNT_OFS: rd_mux = {24'h00_0000, scnt_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `ERS_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? `ERS_RESP_OKAY : `ERS_RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
    begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Operation datapath
  // ---------------------------------------------------------------------------
  // Direct address, no section select
  assign opnd = (32'(cmd_r.addr) < MEM_DEPTH) ?
    mem_r[cmd_r.addr] : 8'h00;
  assign suppress = skip_pend_r;
  assign diff9 = {1'b0, acc_r} - {1'b0, opnd} - {8'h00, ~flags_r.c};
  assign nib5 = {1'b0, acc_r[3:0]} - {1'b0, opnd[3:0]} - {4'h0, ~flags_r.c};

  // Result, enables, flags and skip of the command
  always_comb
  begin
    res = opnd;
    mem_we = 1'b0;
    acc_we = 1'b0;
    flag_we = 1'b0;
    flags_nxt = flags_r;
    is_skip = 1'b0;
    skip_cond = 1'b0;
    unique case (cmd_r.op)
      OP_OR_ACC_INTO_MEMORY:
      begin
        res = acc_r | opnd;
        mem_we = 1'b1;
        flag_we = 1'b1;
        flags_nxt.z = (res == 8'h00);
      end
      OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_TO_ACC:
      begin
        res = {opnd[6:0], opnd[7]};
        mem_we = (cmd_r.op == OP_ROTATE_LEFT_MEM);
        acc_we = (cmd_r.op == OP_ROTATE_LEFT_TO_ACC);
      end
      OP_ROTATE_LEFT_THRU_CARRY_MEM, OP_ROTATE_LEFT_THRU_CARRY_TO_ACC:
      begin
        res = {opnd[6:0], flags_r.c};
        mem_we = (cmd_r.op == OP_ROTATE_LEFT_THRU_CARRY_MEM);
        acc_we = (cmd_r.op == OP_ROTATE_LEFT_THRU_CARRY_TO_ACC);
        flag_we = 1'b1;
        flags_nxt.c = opnd[7];
      end
      OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_TO_ACC:
      begin
        res = {opnd[0], opnd[7:1]};
        mem_we = (cmd_r.op == OP_ROTATE_RIGHT_MEM);
        acc_we = (cmd_r.op == OP_ROTATE_RIGHT_TO_ACC);
      end
      OP_ROTATE_RIGHT_THRU_CARRY_MEM, OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC:
      begin
        res = {flags_r.c, opnd[7:1]};
        mem_we = (cmd_r.op == OP_ROTATE_RIGHT_THRU_CARRY_MEM);
        acc_we = (cmd_r.op == OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC);
        flag_we = 1'b1;
        flags_nxt.c = opnd[0];
      end
      OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_BORROW_TO_MEM:
      begin
        res = diff9[7:0];
        acc_we = (cmd_r.op == OP_SUBTRACT_BORROW_TO_ACC);
        mem_we = (cmd_r.op == OP_SUBTRACT_BORROW_TO_MEM);
        flag_we = 1'b1;
        // Carry reads as no-borrow, nibble carry likewise
        flags_nxt.c = ~diff9[8];
        flags_nxt.nibble_carry_flag = ~nib5[4];
        flags_nxt.z = (diff9[7:0] == 8'h00);
        flags_nxt.overflow_flag = (acc_r[7] ^ opnd[7]) & (acc_r[7] ^ diff9[7]);
        flags_nxt.signed_carry_flag = flags_nxt.overflow_flag ^ diff9[7];
        // Zero carry chains the zero result across multi-byte subtracts
        flags_nxt.zero_carry_flag = flags_nxt.z & flags_r.z;
      end
      OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_TO_ACC_SKIP_ZERO:
      begin
        res = opnd - 8'h01;
        mem_we = (cmd_r.op == OP_DECREMENT_SKIP_ZERO);
        acc_we = (cmd_r.op == OP_DECREMENT_TO_ACC_SKIP_ZERO);
        is_skip = 1'b1;
        skip_cond = (res == 8'h00);
      end
      OP_SET_ONES:
      begin
        res = 8'hff;
        mem_we = 1'b1;
      end
      OP_SET_BIT:
      begin
        res = opnd | (8'h01 << cmd_r.bsel);
        mem_we = 1'b1;
      end
      OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_TO_ACC_SKIP_ZERO:
      begin
        res = opnd + 8'h01;
        mem_we = (cmd_r.op == OP_INCREMENT_SKIP_ZERO);
        acc_we = (cmd_r.op == OP_INCREMENT_TO_ACC_SKIP_ZERO);
        is_skip = 1'b1;
        skip_cond = (res == 8'h00);
      end
      OP_SKIP_IF_NONZERO_BIT:
      begin
        is_skip = 1'b1;
        skip_cond = opnd[cmd_r.bsel];
      end
      OP_SKIP_IF_NONZERO:
      begin
        is_skip = 1'b1;
        skip_cond = (opnd != 8'h00);
      end
      default:
      begin
        res = opnd;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  assign BUSY = (state_r != ST_IDLE);
  assign SKIP_PENDING = skip_pend_r;

  // Idle, one execute cycle, and a dummy cycle after every skip form that a pending skip does not drop
  always_ff @(posedge CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE: state_r <= launch ? ST_EXEC : ST_IDLE;
        ST_EXEC: state_r <= (is_skip && !suppress) ? ST_DUMMY : ST_IDLE;
        ST_DUMMY: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Skip bookkeeping: the next command after a taken skip is dropped
  always_ff @(posedge CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      skip_pend_r <= 1'b0;
      last_skip_r <= 1'b0;
      scnt_r <= 8'h00;
    end
    else if (state_r == ST_EXEC)
    begin
      if (suppress)
      begin
        skip_pend_r <= 1'b0;
        scnt_r <= scnt_r + 8'h01;
      end
      else if (is_skip)
      begin
        skip_pend_r <= skip_cond;
        last_skip_r <= skip_cond;
      end
    end
    else if (do_wr && aw_addr_r == `ERS_SCNT_OFS)
    begin
      scnt_r <= 8'h00;
    end
  end

  // Latched command and memory pointer
  always_ff @(posedge CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cmd_r <= '0;
      mptr_r <= 9'h000;
    end
    else if (do_wr)
    begin
      if (launch)
      begin
        cmd_r.op <= w_data_r[`ERS_CMD_OP_LSB +: 5];
        cmd_r.bsel <= w_data_r[`ERS_CMD_BIT_LSB +: 3];
        cmd_r.addr <= w_data_r[`ERS_CMD_ADDR_LSB +: 9];
      end
      if (aw_addr_r == `ERS_MPTR_OFS)
      begin
        mptr_r <= 9'(merge({23'h00_0000, mptr_r}, w_data_r, w_strb_r));
      end
    end
  end

  // Accumulator and flags, from software or from the executed command
  always_ff @(posedge CLOCK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      acc_r <= `ERS_ACC_RST;
      flags_r <= `ERS_FLAG_RST;
    end
    else if (state_r == ST_EXEC && !suppress)
    begin
      if (acc_we)
      begin
        acc_r <= res;
      end
      if (flag_we)
      begin
        flags_r <= flags_nxt;
      end
    end
    else if (do_wr && aw_addr_r == `ERS_ACC_OFS && w_strb_r[0])
    begin
      acc_r <= w_data_r[7:0];
    end
    else if (do_wr && aw_addr_r == `ERS_FLAG_OFS && w_strb_r[0])
    begin
      flags_r <= w_data_r[5:0];
    end
  end

  // Data memory write port
  always_ff @(posedge CLOCK)
  begin
    if (state_r == ST_EXEC && !suppress && mem_we &&
        32'(cmd_r.addr) < MEM_DEPTH)
    begin
      mem_r[cmd_r.addr] <= res;
    end
    else if (do_wr && aw_addr_r == `ERS_MDAT_OFS && w_strb_r[0] &&
             32'(mptr_r) < MEM_DEPTH)
    begin
      mem_r[mptr_r] <= w_data_r[7:0];
    end
  end

endmodule

// ==== ers_alu_props.sv ====
// Port-level assertions for the extended ALU
`timescale 1ns/1ps
module ers_alu_props
  import ers_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic BUSY,
  input wire logic SKIP_PENDING
);
  // ---------------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------------
  logic [7:0] wa_r;
  logic [7:0] ra_r;
  logic [4:0] op_r;
  logic skip_op;

  // Taken payloads
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wa_r <= 8'h00;
      ra_r <= 8'h00;
      op_r <= 5'h00;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
        wa_r <= S_AXI_AWADDR;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
        ra_r <= S_AXI_ARADDR;
      if (S_AXI_WVALID && S_AXI_WREADY)
        op_r <= S_AXI_WDATA[4:0];
    end
  end

  // Conditional skip forms take the long path
  assign skip_op = op_r >= 5'h0c && op_r <= 5'h13 && op_r != 5'h0e &&
    op_r != 5'h0f;

  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence one_busy;
    BUSY ##1 !BUSY;
  endsequence

  sequence two_busy;
    BUSY ##1 BUSY ##1 !BUSY;
  endsequence

  bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("bvalid dropped");
  rvalid_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("rvalid dropped");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID)
    else $error("read answer late");
  arready_free_a: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
    else $error("arready wrong");
  read_resp_a: assert property (S_AXI_RVALID |-> S_AXI_RRESP ==
    (ra_r[7:2] > 6'd6 ? 2'b10 : 2'b00))
    else $error("rresp wrong");
  write_resp_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP ==
    (wa_r[7:2] > 6'd6 ? 2'b10 : 2'b00))
    else $error("bresp wrong");
  skip_len_a: assert property (
    $rose(BUSY) && skip_op && !$past(SKIP_PENDING) |-> two_busy)
    else $error("skip form not two cycles");
  plain_len_a: assert property (
    $rose(BUSY) && !skip_op && !$past(SKIP_PENDING) |-> one_busy)
    else $error("plain not one cycle");
  skip_cause_a: assert property (
    $rose(SKIP_PENDING) |-> $past(BUSY) && skip_op)
    else $error("stray skip");
  skip_drop_a: assert property (
    $fell(SKIP_PENDING) |-> S_AXI_BVALID || $past(S_AXI_BVALID))
    else $error("skip cleared idle");
endmodule

bind ers_alu ers_alu_props u_props (
  .CLOCK,
  .RST_N,
  .S_AXI_AWADDR,
  .S_AXI_AWVALID,
  .S_AXI_AWREADY,
  .S_AXI_WDATA,
  .S_AXI_WVALID,
  .S_AXI_WREADY,
  .S_AXI_BRESP,
  .S_AXI_BVALID,
  .S_AXI_BREADY,
  .S_AXI_ARADDR,
  .S_AXI_ARVALID,
  .S_AXI_ARREADY,
  .S_AXI_RDATA,
  .S_AXI_RRESP,
  .S_AXI_RVALID,
  .S_AXI_RREADY,
  .BUSY,
  .SKIP_PENDING
);

// ==== tb_top.sv ====
// Self-checking bench for the extended ALU
`timescale 1ns/1ps
module tb_top
  import ers_pkg::*;
;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b1;
  logic arvalid = 1'b0;
  logic rready = 1'b1;
  wire awready, wready, bvalid, arready, rvalid, busy, skp;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  logic [31:0] rd;
  logic [1:0] resp;
  int err_count = 0;
  int tests_run = 0;

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  ers_alu #(.MEM_DEPTH(384)) dut (
    .CLOCK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .BUSY(busy),
    .SKIP_PENDING(skp)
  );

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_b(input string nm, input logic e, g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Handshakes judged at rising edges; bready and rready stay high
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end
    while (!bvalid && n < 100);
    resp = bresp;
    if (!bvalid) err_count++;
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end
    while (!rvalid && n < 100);
    rd = rdata;
    resp = rresp;
    if (!rvalid) err_count++;
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Operation helpers
  // ---------------------------------------------------------------------
  task automatic mget(input logic [8:0] m);
    wr(8'h0c, {23'h0, m});
    rdr(8'h10);
  endtask

  task automatic prep(input logic [8:0] m, input logic [7:0] v, a,
    input logic [5:0] f);
    wr(8'h0c, {23'h0, m});
    wr(8'h10, {24'h0, v});
    wr(8'h04, {24'h0, a});
    wr(8'h08, {26'h0, f});
  endtask

  // Launch a command, wait for idle
  task automatic run(input logic [4:0] op, input logic [2:0] b,
    input logic [8:0] m);
    int n;
    wr(8'h00, {7'h0, m, 5'h0, b, 3'h0, op});
    n = 0;
    while (busy && n < 20)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic chkst(input logic [8:0] m, input logic [7:0] em, ea,
    input logic [5:0] ef);
    mget(m);
    chk("memory byte", {24'h0, em}, rd);
    rdr(8'h04);
    chk("accumulator", {24'h0, ea}, rd);
    rdr(8'h08);
    chk("flags", {26'h0, ef}, rd);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_bus();
    wr(8'h10, 32'h0);
    chkst(9'h000, 8'h00, 8'h00, 6'h00);
    rdr(8'h1c);
    chk("unmapped read", 32'h2, {30'h0, resp});
    chk("unmapped data", 32'h0, rd);
    wr(8'h1c, 32'h5a);
    chk("unmapped write", 32'h2, {30'h0, resp});
    rdr(8'h04);
    chk("accumulator kept", 32'h0, rd);
  endtask

  task automatic t_or();
    prep(9'h17f, 8'h50, 8'h0a, 6'h3f);
    run(5'h01, 3'h0, 9'h17f);
    chkst(9'h17f, 8'h5a, 8'h0a, 6'h3b);
    prep(9'h005, 8'h00, 8'h00, 6'h00);
    run(5'h01, 3'h0, 9'h005);
    chkst(9'h005, 8'h00, 8'h00, 6'h04);
  endtask

  // Rotates, carry clear and set; odd codes to acc
  task automatic t_rot();
    logic [7:0] v, r;
    logic [5:0] f, ef;
    logic c;
    for (int op = 2; op < 10; op++)
      for (int k = 0; k < 2; k++)
      begin
        c = k[0];
        v = c ? 8'h69 : 8'h96;
        f = c ? 6'h2b : 6'h14;
        r = op < 6 ? (op < 4 ? {v[6:0], v[7]} : {v[6:0], c}) :
          (op < 8 ? {v[0], v[7:1]} : {c, v[7:1]});
        ef = (op == 4 || op == 5) ? {f[5:1], v[7]} :
          (op > 7 ? {f[5:1], v[0]} : f);
        prep(9'h0a3, v, 8'h3c, f);
        run(op[4:0], 3'h0, 9'h0a3);
        chkst(9'h0a3, op[0] ? v : r, op[0] ? r : 8'h3c, ef);
      end
  endtask

  task automatic sbc(input logic [4:0] op, input logic [7:0] a, m, r,
    input logic [5:0] f, ef);
    prep(9'h0c0, m, a, f);
    run(op, 3'h0, 9'h0c0);
    chkst(9'h0c0, op[0] ? r : m, op[0] ? a : r, ef);
  endtask

  task automatic t_sub();
    sbc(5'h0a, 8'h10, 8'h20, 8'hf0, 6'h01, 6'h12);
    sbc(5'h0b, 8'h80, 8'h00, 8'h7f, 6'h00, 6'h19);
    sbc(5'h0a, 8'h05, 8'h05, 8'h00, 6'h05, 6'h27);
  endtask

  task automatic t_set();
    prep(9'h101, 8'h00, 8'h3c, 6'h2a);
    run(5'h0f, 3'h3, 9'h101);
    chkst(9'h101, 8'h08, 8'h3c, 6'h2a);
    run(5'h0f, 3'h7, 9'h101);
    chkst(9'h101, 8'h88, 8'h3c, 6'h2a);
    run(5'h0e, 3'h0, 9'h101);
    chkst(9'h101, 8'hff, 8'h3c, 6'h2a);
  endtask

  // Skip form, then a set-ones that a taken skip drops
  task automatic sk(input logic [4:0] op, input logic [2:0] b,
    input logic [7:0] v, em, ea, input logic t);
    prep(9'h040, v, 8'h3c, 6'h15);
    wr(8'h0c, 32'h0ff);
    wr(8'h10, 32'h0);
    run(op, b, 9'h040);
    chk_b("skip pending", t, skp);
    chkst(9'h040, em, ea, 6'h15);
    run(5'h0e, 3'h0, 9'h0ff);
    chk_b("skip cleared", 1'b0, skp);
    mget(9'h0ff);
    chk("following command", t ? 32'h0 : 32'hff, rd);
  endtask

  task automatic t_skip();
    sk(5'h0c, 3'h0, 8'h01, 8'h00, 8'h3c, 1'b1);
    sk(5'h0c, 3'h0, 8'h05, 8'h04, 8'h3c, 1'b0);
    sk(5'h0d, 3'h0, 8'h01, 8'h01, 8'h00, 1'b1);
    sk(5'h10, 3'h0, 8'hff, 8'h00, 8'h3c, 1'b1);
    sk(5'h11, 3'h0, 8'hff, 8'hff, 8'h00, 1'b1);
    sk(5'h11, 3'h0, 8'h10, 8'h10, 8'h11, 1'b0);
    sk(5'h12, 3'h5, 8'h20, 8'h20, 8'h3c, 1'b1);
    sk(5'h12, 3'h4, 8'h20, 8'h20, 8'h3c, 1'b0);
    sk(5'h13, 3'h0, 8'h01, 8'h01, 8'h3c, 1'b1);
    sk(5'h13, 3'h0, 8'h00, 8'h00, 8'h3c, 1'b0);
    rdr(8'h18);
    chk("dropped count", 32'h6, rd);
    wr(8'h18, 32'h0);
    rdr(8'h18);
    chk("count cleared", 32'h0, rd);
  endtask

  // ---------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_bus();
    t_or();
    t_rot();
    t_sub();
    t_set();
    t_skip();
    wrap_up();
  end

  // Cuts a hung handshake short
  initial
  begin
    #500000;
    err_count++;
    wrap_up();
  end
endmodule
